// ---- design/dbws_status_bank.sv ----
/*
 * Status register bank: device history before restart, CAN transceiver
 * fault and supply status, and latched wake-up source flags.
 * Assumes the serial interface decoder sits outside and hands over
 * one-cycle read and clear strobes on clk_sys; all event inputs come from
 * logic on clk_sys except the analog supply comparator, which is synchronised.
 */
// Overview of operation
// - Previous-mode field: 00 clear, 01 fail, 10 sleep
// - Failure events load previous-mode code 01
// - Sleep attempt with pending wake flags reports 10
// - Watchdog fail counter in bits 3:2, saturating
// - Watchdog counter cleared by device automatically
// - Configurations 2/4 freeze counter until good trigger
// - Invalid serial command sets serial-failure flag
// - Serial-failure flag cleared only by host command, soft reset or reset
// - Fail output activation sets failure flag
// - Supply undervoltage sets flag, disables transmitter
// - Undervoltage detection only while CAN mode bit set
// - Wake from fail-safe also sets source flag
// - Reserved bits always read zero
// - Soft reset zeroes history; restart keeps fields, except a saturated watchdog count in configurations 1/3
// - Restart keeps documented bus and wake bits
`timescale 1ns/1ps

module dbws_status_bank (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic soft_reset,
	input wire logic restart_entry,
	input wire logic rd_en,
	input wire logic clr_en,
	input wire logic [6:0] reg_addr,
	input wire logic [7:0] clr_mask,
	input wire logic wd_trigger_ok,
	input wire logic wd_trigger_fail,
	input wire logic [1:0] fail_config_select,
	input wire logic severe_thermal_shutdown,
	input wire logic main_rail_undervoltage,
	input wire logic sleep_no_wake_source,
	input wire logic sleep_entry,
	input wire logic sleep_with_flags,
	input wire logic failsafe_wake,
	input wire logic [2:0] failsafe_wake_src,
	input wire logic fail_output_request,
	input wire logic invalid_serial_cmd,
	input wire logic can_fail_evt,
	input wire logic [1:0] can_fail_code,
	input wire logic can_mode_active,
	input wire logic transceiver_supply_low,
	input wire logic bus_wake_evt,
	input wire logic timer_wake_evt,
	input wire logic hv_input_wake_evt,
	output logic [7:0] rdata_q,
	output logic rvalid_q,
	output logic fail_output_pin_q,
	output logic tx_disable_q
);
	// ********************************************************************
	// State
	// ********************************************************************
	typedef struct packed {
		logic [1:0] prev_mode_code;
		logic [1:0] watchdog_fail_count;
		logic serial_fail;
		logic failure;
		logic [1:0] can_fail;
		logic supply_low_flag;
		logic bus_wake_flag;
		logic timer_wake_flag;
		logic hv_input_wake_flag;
		logic supply_sync1;
		logic supply_sync2;
		logic [7:0] rdata;
		logic rvalid;
		logic fail_output;
		logic tx_disable;
	} dbws_state_s;

	dbws_state_s state_q;
	dbws_state_s state_d;

	logic [7:0] dev_hist;
	logic [7:0] bus_stat;
	logic [7:0] wake_stat;
	logic [1:0] wd_threshold;
	logic wd_fo_activate;
	logic wd_freeze;
	logic fail_event;
	logic clr_dev;
	logic clr_bus;
	logic clr_wake;

	// ********************************************************************
	// Register images
	// ********************************************************************
	// Reserved positions are forced to zero by the implemented-bit masks
	always_comb begin
		dev_hist = 8'h00;
		dev_hist[dbws_pkg::PREV_MODE_LSB +: 2] = state_q.prev_mode_code;
		dev_hist[dbws_pkg::WD_COUNT_LSB +: 2] = state_q.watchdog_fail_count;
		dev_hist[dbws_pkg::SERIAL_FAIL_BIT] = state_q.serial_fail;
		dev_hist[dbws_pkg::FAILURE_BIT] = state_q.failure;
		dev_hist = dev_hist & dbws_pkg::MASK_DEVICE_HISTORY;
		bus_stat = 8'h00;
		bus_stat[dbws_pkg::CAN_FAIL_LSB +: 2] = state_q.can_fail;
		bus_stat[dbws_pkg::SUPPLY_LOW_BIT] = state_q.supply_low_flag;
		bus_stat = bus_stat & dbws_pkg::MASK_BUS_COMM;
		wake_stat = 8'h00;
		wake_stat[dbws_pkg::BUS_WAKE_BIT] = state_q.bus_wake_flag;
		wake_stat[dbws_pkg::TIMER_WAKE_BIT] = state_q.timer_wake_flag;
		wake_stat[dbws_pkg::HV_WAKE_BIT] = state_q.hv_input_wake_flag;
		wake_stat = wake_stat & dbws_pkg::MASK_WAKE_SOURCE;
	end

	// ********************************************************************
	// Watchdog failure policy
	// ********************************************************************
	// Configuration 2 activates the fail output after one failure, the others after two
	always_comb begin
		case (fail_config_select)
			dbws_pkg::FAIL_CFG_2: wd_threshold = dbws_pkg::WD_COUNT_ONE;
			default: wd_threshold = dbws_pkg::WD_COUNT_TWO;
		endcase
		wd_freeze = (fail_config_select == dbws_pkg::FAIL_CFG_2) ||
			(fail_config_select == dbws_pkg::FAIL_CFG_4);
		wd_fo_activate = wd_trigger_fail &&
			(state_q.watchdog_fail_count == wd_threshold - 2'h1);
		fail_event = (wd_trigger_fail && (state_q.watchdog_fail_count >= wd_threshold -
			2'h1)) || severe_thermal_shutdown || main_rail_undervoltage ||
			sleep_no_wake_source || failsafe_wake;
		clr_dev = clr_en && (reg_addr == dbws_pkg::ADDR_DEVICE_HISTORY_STATUS);
		clr_bus = clr_en && (reg_addr == dbws_pkg::ADDR_BUS_COMM_STATUS);
		clr_wake = clr_en && (reg_addr == dbws_pkg::ADDR_WAKE_SOURCE_STATUS_A);
	end

	// ********************************************************************
	// Next state
	// ********************************************************************
	// Host clears are applied first, so an event in the same cycle wins
	always_comb begin
		state_d = state_q;
		state_d.rvalid = 1'b0;

		// Comparator output is asynchronous to clk_sys
		state_d.supply_sync1 = transceiver_supply_low;
		state_d.supply_sync2 = state_q.supply_sync1;

		// Host clear commands
		if (clr_dev) begin
			if (clr_mask[dbws_pkg::PREV_MODE_LSB] || clr_mask[dbws_pkg::PREV_MODE_LSB + 1]) begin
				state_d.prev_mode_code = dbws_pkg::PREV_MODE_CLEARED;
			end
			if (clr_mask[dbws_pkg::SERIAL_FAIL_BIT]) begin
				state_d.serial_fail = 1'b0;
			end
			if (clr_mask[dbws_pkg::FAILURE_BIT]) begin
				state_d.failure = 1'b0;
			end
		end
		if (clr_bus) begin
			if (clr_mask[dbws_pkg::CAN_FAIL_LSB] || clr_mask[dbws_pkg::CAN_FAIL_LSB + 1]) begin
				state_d.can_fail = dbws_pkg::CAN_FAIL_NONE;
			end
			if (clr_mask[dbws_pkg::SUPPLY_LOW_BIT]) begin
				state_d.supply_low_flag = 1'b0;
			end
		end
		if (clr_wake) begin
			if (clr_mask[dbws_pkg::BUS_WAKE_BIT]) begin
				state_d.bus_wake_flag = 1'b0;
			end
			if (clr_mask[dbws_pkg::TIMER_WAKE_BIT]) begin
				state_d.timer_wake_flag = 1'b0;
			end
			if (clr_mask[dbws_pkg::HV_WAKE_BIT]) begin
				state_d.hv_input_wake_flag = 1'b0;
			end
		end

		// Watchdog failure counter; the host has no way to clear it
		if (wd_trigger_ok) begin
			state_d.watchdog_fail_count = dbws_pkg::WD_COUNT_NONE;
		end else if (wd_trigger_fail) begin
			if (state_q.watchdog_fail_count < wd_threshold) begin
				state_d.watchdog_fail_count = state_q.watchdog_fail_count + 2'h1;
			end
		end else if (!wd_freeze && restart_entry &&
			(state_q.watchdog_fail_count >= wd_threshold)) begin
			// Configurations 1/3 start over once the restart has been taken
			state_d.watchdog_fail_count = dbws_pkg::WD_COUNT_NONE;
		end
		// In configurations 2/4 only a good trigger releases the counter

		// Fail output activation
		if (wd_fo_activate || fail_output_request) begin
			state_d.fail_output = 1'b1;
			state_d.failure = 1'b1;
		end else if (wd_trigger_ok) begin
			state_d.fail_output = 1'b0;
		end

		// Previous-mode code; a failure outranks a sleep report
		if (fail_event) begin
			state_d.prev_mode_code = dbws_pkg::PREV_MODE_FAILURE;
		end else if (sleep_entry || sleep_with_flags) begin
			state_d.prev_mode_code = dbws_pkg::PREV_MODE_SLEEP;
		end

		// Serial interface failure
		if (invalid_serial_cmd) begin
			state_d.serial_fail = 1'b1;
		end

		// CAN failure code; a new fault overwrites the old one
		if (can_fail_evt && (can_fail_code != dbws_pkg::CAN_FAIL_NONE)) begin
			state_d.can_fail = can_fail_code;
		end

		// Supply undervoltage, watched only in normal or receive-only mode
		if (can_mode_active && state_q.supply_sync2) begin
			state_d.supply_low_flag = 1'b1;
		end
		state_d.tx_disable = state_d.supply_low_flag;

		// Wake flags, including the source of a fail-safe wake
		if (bus_wake_evt || (failsafe_wake && failsafe_wake_src[dbws_pkg::WAKE_SRC_BUS])) begin
			state_d.bus_wake_flag = 1'b1;
		end
		if (timer_wake_evt ||
			(failsafe_wake && failsafe_wake_src[dbws_pkg::WAKE_SRC_TIMER])) begin
			state_d.timer_wake_flag = 1'b1;
		end
		if (hv_input_wake_evt ||
			(failsafe_wake && failsafe_wake_src[dbws_pkg::WAKE_SRC_HV])) begin
			state_d.hv_input_wake_flag = 1'b1;
		end

		// Restart: only the bits outside the keep masks drop
		if (restart_entry) begin
			state_d.can_fail = state_d.can_fail &
				dbws_pkg::KEEP_BUS_COMM[dbws_pkg::CAN_FAIL_LSB +: 2];
			state_d.supply_low_flag = state_d.supply_low_flag &
				dbws_pkg::KEEP_BUS_COMM[dbws_pkg::SUPPLY_LOW_BIT];
			state_d.bus_wake_flag = state_d.bus_wake_flag &
				dbws_pkg::KEEP_WAKE_SOURCE[dbws_pkg::BUS_WAKE_BIT];
			state_d.timer_wake_flag = state_d.timer_wake_flag &
				dbws_pkg::KEEP_WAKE_SOURCE[dbws_pkg::TIMER_WAKE_BIT];
			state_d.hv_input_wake_flag = state_d.hv_input_wake_flag &
				dbws_pkg::KEEP_WAKE_SOURCE[dbws_pkg::HV_WAKE_BIT];
			state_d.prev_mode_code = state_d.prev_mode_code &
				dbws_pkg::KEEP_DEVICE_HISTORY[dbws_pkg::PREV_MODE_LSB +: 2];
		end

		// Read port: unmapped addresses answer zero
		if (rd_en) begin
			state_d.rvalid = 1'b1;
			case (reg_addr)
				dbws_pkg::ADDR_DEVICE_HISTORY_STATUS: state_d.rdata = dev_hist;
				dbws_pkg::ADDR_BUS_COMM_STATUS: state_d.rdata = bus_stat;
				dbws_pkg::ADDR_WAKE_SOURCE_STATUS_A: state_d.rdata = wake_stat;
				default: state_d.rdata = 8'h00;
			endcase
		end

		// Soft reset returns every register to its power-on value
		if (soft_reset) begin
			state_d.prev_mode_code = dbws_pkg::RST_DEVICE_HISTORY[dbws_pkg::PREV_MODE_LSB +: 2];
			state_d.watchdog_fail_count =
				dbws_pkg::RST_DEVICE_HISTORY[dbws_pkg::WD_COUNT_LSB +: 2];
			state_d.serial_fail = dbws_pkg::RST_DEVICE_HISTORY[dbws_pkg::SERIAL_FAIL_BIT];
			state_d.failure = dbws_pkg::RST_DEVICE_HISTORY[dbws_pkg::FAILURE_BIT];
			state_d.can_fail = dbws_pkg::RST_BUS_COMM[dbws_pkg::CAN_FAIL_LSB +: 2];
			state_d.supply_low_flag = dbws_pkg::RST_BUS_COMM[dbws_pkg::SUPPLY_LOW_BIT];
			state_d.bus_wake_flag = dbws_pkg::RST_WAKE_SOURCE[dbws_pkg::BUS_WAKE_BIT];
			state_d.timer_wake_flag = dbws_pkg::RST_WAKE_SOURCE[dbws_pkg::TIMER_WAKE_BIT];
			state_d.hv_input_wake_flag = dbws_pkg::RST_WAKE_SOURCE[dbws_pkg::HV_WAKE_BIT];
			state_d.fail_output = 1'b0;
			state_d.tx_disable = 1'b0;
		end
	end

	// ********************************************************************
	// Registers
	// ********************************************************************
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	assign rdata_q = state_q.rdata;
	assign rvalid_q = state_q.rvalid;
	assign fail_output_pin_q = state_q.fail_output;
	assign tx_disable_q = state_q.tx_disable;
endmodule

// ---- design/dbws_pkg.sv ----
/*
 * Constants for the device history, bus status and wake source status bank.
 * Assumes a 7-bit register address space and 8-bit status registers.
 */
package dbws_pkg;
	// ********************************************************************
	// Register addresses
	// ********************************************************************
	localparam logic [6:0] ADDR_DEVICE_HISTORY_STATUS = 7'h43;
	localparam logic [6:0] ADDR_BUS_COMM_STATUS = 7'h44;
	localparam logic [6:0] ADDR_WAKE_SOURCE_STATUS_A = 7'h46;

	// ********************************************************************
	// Reset values and implemented-bit masks
	// ********************************************************************
	localparam logic [7:0] RST_DEVICE_HISTORY = 8'h00;
	localparam logic [7:0] RST_BUS_COMM = 8'h00;
	localparam logic [7:0] RST_WAKE_SOURCE = 8'h00;
	localparam logic [7:0] MASK_DEVICE_HISTORY = 8'hcf;
	localparam logic [7:0] MASK_BUS_COMM = 8'h07;
	localparam logic [7:0] MASK_WAKE_SOURCE = 8'h31;
	// Bits that survive a restart, except a saturated watchdog count in configurations 1/3; all others go to zero
	localparam logic [7:0] KEEP_DEVICE_HISTORY = 8'hcf;
	localparam logic [7:0] KEEP_BUS_COMM = 8'h07;
	localparam logic [7:0] KEEP_WAKE_SOURCE = 8'h39;

	// ********************************************************************
	// Field positions
	// ********************************************************************
	localparam int PREV_MODE_LSB = 6;
	localparam int WD_COUNT_LSB = 2;
	localparam int SERIAL_FAIL_BIT = 1;
	localparam int FAILURE_BIT = 0;
	localparam int CAN_FAIL_LSB = 1;
	localparam int SUPPLY_LOW_BIT = 0;
	localparam int BUS_WAKE_BIT = 5;
	localparam int TIMER_WAKE_BIT = 4;
	localparam int HV_WAKE_BIT = 0;

	// ********************************************************************
	// Field encodings
	// ********************************************************************
	localparam logic [1:0] PREV_MODE_CLEARED = 2'h0;
	localparam logic [1:0] PREV_MODE_FAILURE = 2'h1;
	localparam logic [1:0] PREV_MODE_SLEEP = 2'h2;
	localparam logic [1:0] WD_COUNT_NONE = 2'h0;
	localparam logic [1:0] WD_COUNT_ONE = 2'h1;
	localparam logic [1:0] WD_COUNT_TWO = 2'h2;
	localparam logic [1:0] CAN_FAIL_NONE = 2'h0;
	localparam logic [1:0] CAN_FAIL_THERMAL = 2'h1;
	localparam logic [1:0] CAN_FAIL_TX_DOM = 2'h2;
	localparam logic [1:0] CAN_FAIL_BUS_DOM = 2'h3;
	// Fail configuration select codes, configurations 1 to 4
	localparam logic [1:0] FAIL_CFG_1 = 2'h0;
	localparam logic [1:0] FAIL_CFG_2 = 2'h1;
	localparam logic [1:0] FAIL_CFG_3 = 2'h2;
	localparam logic [1:0] FAIL_CFG_4 = 2'h3;
	// Wake source vector positions: bus, timer, high-voltage input
	localparam int WAKE_SRC_BUS = 2;
	localparam int WAKE_SRC_TIMER = 1;
	localparam int WAKE_SRC_HV = 0;
endpackage

// ---- bench/dbws_status_bank_asserts.sv ----
/* Port checker for the status bank.
 * Assumes it is bound to dbws_status_bank and sees only its ports. */
`timescale 1ns/1ps
module dbws_status_bank_asserts (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic soft_reset,
	input wire logic rd_en,
	input wire logic clr_en,
	input wire logic [6:0] reg_addr,
	input wire logic wd_trigger_ok,
	input wire logic fail_output_request,
	input wire logic invalid_serial_cmd,
	input wire logic can_mode_active,
	input wire logic transceiver_supply_low,
	input wire logic bus_wake_evt,
	input wire logic [7:0] rdata_q,
	input wire logic rvalid_q,
	input wire logic fail_output_pin_q,
	input wire logic tx_disable_q
);
	// ****************
	// Properties
	// ****************
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	a_hist_fields: assert property (rvalid_q && $past(reg_addr) == 7'h43 |->
		rdata_q[5:4] == 2'h0 && rdata_q[7:6] != 2'h3 && rdata_q[3:2] != 2'h3)
		else $error("history read has bad field");
	a_resv_bus: assert property (rvalid_q && $past(reg_addr) == 7'h44 |-> rdata_q[7:3] == 5'h00)
		else $error("bus status reserved bits set");
	a_resv_wake: assert property (rvalid_q && $past(reg_addr) == 7'h46 |->
		rdata_q[7:6] == 2'h0 && rdata_q[3:1] == 3'h0) else $error("wake reserved bits set");
	a_unmapped_zero: assert property (rd_en && reg_addr == 7'h45 |=> rvalid_q && rdata_q == 8'h00)
		else $error("unmapped read not zero");
	a_txdis_cause: assert property ($rose(tx_disable_q) |->
		$past(transceiver_supply_low, 3) && $past(can_mode_active)) else $error("tx disable without cause");
	a_fail_pin_set: assert property (fail_output_request && !soft_reset && !wd_trigger_ok |=>
		fail_output_pin_q) else $error("fail output not raised");
	a_soft_clear: assert property (soft_reset |=> !fail_output_pin_q && !tx_disable_q)
		else $error("soft reset left outputs high");
	a_serial_set: assert property (invalid_serial_cmd && !soft_reset ##1 !soft_reset && !clr_en
		##1 rd_en && reg_addr == 7'h43 |=> rdata_q[1]) else $error("serial fail flag missing");
	a_bus_wake_set: assert property (bus_wake_evt && !soft_reset ##1 !soft_reset && !clr_en
		##1 rd_en && reg_addr == 7'h46 |=> rdata_q[5]) else $error("bus wake flag missing");
endmodule
bind dbws_status_bank dbws_status_bank_asserts u_chk (.clk_sys, .resetn, .soft_reset, .rd_en,
	.clr_en, .reg_addr, .wd_trigger_ok, .fail_output_request, .invalid_serial_cmd, .can_mode_active,
	.transceiver_supply_low, .bus_wake_evt, .rdata_q, .rvalid_q, .fail_output_pin_q, .tx_disable_q);

// ---- bench/dbws_host_model.sv ----
/* Host side of the serial register access: read and clear commands.
 * Assumes one-cycle strobes taken on the rising clk_sys edge. */
`timescale 1ns/1ps
module dbws_host_model (
	input wire logic clk_sys,
	input wire logic [7:0] rdata_q,
	input wire logic rvalid_q,
	output logic rd_en,
	output logic clr_en,
	output logic [6:0] reg_addr,
	output logic [7:0] clr_mask
);
	initial begin
		rd_en = 1'b0;
		clr_en = 1'b0;
		reg_addr = 7'h00;
		clr_mask = 8'h00;
	end
	task automatic rd(input logic [6:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		rd_en <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		rd_en <= 1'b0;
		// Released address shows garbage so a stale value cannot look valid
		reg_addr <= ~a;
		#1 d = rvalid_q ? rdata_q : 8'hee;
	endtask
	// Besides reset, flags only go back to zero through this command or a soft reset
	task automatic clr(input logic [6:0] a, input logic [7:0] m);
		@(posedge clk_sys);
		clr_en <= 1'b1;
		reg_addr <= a;
		clr_mask <= m;
		@(posedge clk_sys);
		clr_en <= 1'b0;
		reg_addr <= ~a;
		clr_mask <= ~m;
	endtask
endmodule

// ---- bench/tb.sv ----
/* Self-checking bench for the status bank.
 * Assumes the host model drives the register strobes. */
`timescale 1ns/1ps
module tb;
	localparam logic [6:0] A_H = dbws_pkg::ADDR_DEVICE_HISTORY_STATUS;
	localparam logic [6:0] A_B = dbws_pkg::ADDR_BUS_COMM_STATUS;
	localparam logic [6:0] A_W = dbws_pkg::ADDR_WAKE_SOURCE_STATUS_A;
	logic clk_sys, resetn, can_mode, supply_low, rd_en, clr_en, rvalid_q, fail_pin, tx_dis;
	logic [15:0] ev;
	logic [1:0] cfg, code;
	logic [2:0] src;
	logic [6:0] reg_addr;
	logic [7:0] clr_mask, rdata_q;
	int checks, miscompares, cyc;
	dbws_status_bank u_dut (.clk_sys, .resetn, .soft_reset(ev[0]), .restart_entry(ev[1]), .rd_en,
		.clr_en, .reg_addr, .clr_mask, .wd_trigger_ok(ev[2]), .wd_trigger_fail(ev[3]),
		.fail_config_select(cfg), .severe_thermal_shutdown(ev[4]), .main_rail_undervoltage(ev[5]),
		.sleep_no_wake_source(ev[6]), .sleep_entry(ev[7]), .sleep_with_flags(ev[8]),
		.failsafe_wake(ev[9]), .failsafe_wake_src(src), .fail_output_request(ev[10]),
		.invalid_serial_cmd(ev[11]), .can_fail_evt(ev[12]), .can_fail_code(code),
		.can_mode_active(can_mode), .transceiver_supply_low(supply_low), .bus_wake_evt(ev[13]),
		.timer_wake_evt(ev[14]), .hv_input_wake_evt(ev[15]), .rdata_q, .rvalid_q,
		.fail_output_pin_q(fail_pin), .tx_disable_q(tx_dis));
	dbws_host_model u_host (.clk_sys, .rdata_q, .rvalid_q, .rd_en, .clr_en, .reg_addr, .clr_mask);
	// ****************
	// Shared tasks
	// ****************
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic fire(input logic [15:0] v);
		@(posedge clk_sys);
		ev <= v;
		@(posedge clk_sys);
		ev <= '0;
	endtask
	task automatic rc(input logic [6:0] a, input logic [7:0] e);
		logic [7:0] d;
		u_host.rd(a, d);
		chk(d, e);
	endtask
	task automatic summarize;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// ****************
	// Scenarios
	// ****************
	task automatic t_prev;
		logic [15:0] evs [6];
		logic [7:0] em [6];
		evs = '{16'h0010, 16'h0020, 16'h0040, 16'h0200, 16'h0080, 16'h0100};
		em = '{8'h40, 8'h40, 8'h40, 8'h40, 8'h80, 8'h80};
		rc(A_H, 8'h00);
		rc(7'h45, 8'h00);
		for (int i = 0; i < 6; i++) begin
			fire(evs[i]);
			rc(A_H, em[i]);
			rc(A_H, em[i]);
			u_host.clr(A_H, 8'hc0);
			rc(A_H, 8'h00);
		end
		// Failure code outranks sleep code in the same cycle
		fire(16'h0090);
		rc(A_H, 8'h40);
		u_host.clr(A_H, 8'hc0);
		$display("t_prev done");
	endtask
	task automatic t_wd;
		@(posedge clk_sys);
		cfg <= dbws_pkg::FAIL_CFG_2;
		fire(16'h0008);
		rc(A_H, 8'h45);
		chk({7'h00, fail_pin}, 8'h01);
		fire(16'h0002);
		rc(A_H, 8'h45);
		u_host.clr(A_H, 8'hff);
		rc(A_H, 8'h04);
		fire(16'h0004);
		rc(A_H, 8'h00);
		chk({7'h00, fail_pin}, 8'h00);
		@(posedge clk_sys);
		cfg <= dbws_pkg::FAIL_CFG_1;
		fire(16'h0008);
		rc(A_H, 8'h04);
		fire(16'h0008);
		rc(A_H, 8'h49);
		fire(16'h0002);
		rc(A_H, 8'h41);
		fire(16'h0004);
		u_host.clr(A_H, 8'hff);
		rc(A_H, 8'h00);
		// Configuration 4: two failures, then the count survives a restart
		@(posedge clk_sys);
		cfg <= dbws_pkg::FAIL_CFG_4;
		fire(16'h0008);
		fire(16'h0008);
		fire(16'h0002);
		rc(A_H, 8'h49);
		chk({7'h00, fail_pin}, 8'h01);
		fire(16'h0004);
		u_host.clr(A_H, 8'hff);
		rc(A_H, 8'h00);
		$display("t_wd done");
	endtask
	task automatic t_ser;
		fire(16'h0c00);
		rc(A_H, 8'h03);
		fire(16'h0002);
		rc(A_H, 8'h03);
		u_host.clr(A_H, 8'h03);
		rc(A_H, 8'h00);
		fire(16'h0c00);
		fire(16'h0001);
		rc(A_H, 8'h00);
		chk({7'h00, fail_pin}, 8'h00);
		$display("t_ser done");
	endtask
	task automatic t_can;
		@(posedge clk_sys);
		can_mode <= 1'b1;
		for (int c = 1; c < 4; c++) begin
			@(posedge clk_sys);
			code <= c[1:0];
			fire(16'h1000);
			rc(A_B, {5'h00, c[1:0], 1'b0});
			u_host.clr(A_B, 8'h06);
		end
		rc(A_B, 8'h00);
		fire(16'h1000);
		@(posedge clk_sys);
		supply_low <= 1'b1;
		repeat (5) @(posedge clk_sys);
		supply_low <= 1'b0;
		#1 chk({7'h00, tx_dis}, 8'h01);
		fire(16'h0002);
		rc(A_B, 8'h07);
		u_host.clr(A_B, 8'h07);
		rc(A_B, 8'h00);
		chk({7'h00, tx_dis}, 8'h00);
		@(posedge clk_sys);
		can_mode <= 1'b0;
		supply_low <= 1'b1;
		repeat (6) @(posedge clk_sys);
		supply_low <= 1'b0;
		rc(A_B, 8'h00);
		$display("t_can done");
	endtask
	task automatic t_wake;
		fire(16'h2000);
		rc(A_W, 8'h20);
		fire(16'h4000);
		rc(A_W, 8'h30);
		fire(16'h8000);
		rc(A_W, 8'h31);
		fire(16'h0002);
		rc(A_W, 8'h31);
		u_host.clr(A_W, 8'h31);
		rc(A_W, 8'h00);
		@(posedge clk_sys);
		src <= 3'h7;
		fire(16'h0200);
		rc(A_W, 8'h31);
		rc(A_H, 8'h40);
		fire(16'h0001);
		rc(A_W, 8'h00);
		rc(A_H, 8'h00);
		$display("t_wake done");
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	initial begin
		resetn = 1'b0;
		ev = '0;
		cfg = 2'h0;
		code = 2'h0;
		src = 3'h0;
		can_mode = 1'b0;
		supply_low = 1'b0;
		checks = 0;
		miscompares = 0;
		repeat (2) @(posedge clk_sys);
		resetn <= 1'b1;
		t_prev;
		t_wd;
		t_ser;
		t_can;
		t_wake;
		summarize;
	end
	// Hang guard, well above the few hundred cycles the run needs
	initial cyc = 0;
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			miscompares++;
			summarize;
		end
	end
endmodule
